//--- verilog/hsil_pkg.sv
package hsil_pkg;
	// ==================================================
	// Register map
	localparam logic [7:0] LINK_IRQ_ENABLE_TWO_ADDR = 8'h00;
	localparam logic [7:0] SS7_EVENT_STATUS_ADDR = 8'h04;
	localparam logic [7:0] SS7_EVENT_ENABLE_ADDR = 8'h08;
	localparam logic [7:0] LINK_STATUS_ADDR = 8'h0c;
	localparam logic [7:0] CRC_CTRL_ADDR = 8'h10;
	// ==================================================
	// Field positions
	localparam int FCS_BIT = 2;
	localparam int ABORT_BIT = 1;
	localparam int IDLE_BIT = 0;
	localparam int TX_START_BIT = 5;
	localparam int RX_START_BIT = 4;
	localparam int TX_END_BIT = 3;
	localparam int RX_END_BIT = 2;
	localparam int CRC_FAIL_BIT = 1;
	localparam int OVERSIZE_BIT = 0;
	localparam int THRESH_SEL_BIT = 0;
	// ==================================================
	// Reset values and limits
	localparam logic [2:0] LINK_EN_RESET = 3'h0;
	localparam logic [5:0] SS7_EN_RESET = 6'h00;
	localparam logic [5:0] SS7_STAT_RESET = 6'h00;
	localparam logic [2:0] LINK_STAT_RESET = 3'h0;
	localparam logic [6:0] CRC_THRESH_LOW = 7'h20;
	localparam logic [6:0] CRC_THRESH_HIGH = 7'h40;
	localparam logic [8:0] MAX_MSG_BYTES = 9'h114;
	localparam logic [7:0] FLAG_OCTET = 8'h7e;
	localparam int ABORT_ONES = 7;
endpackage : hsil_pkg

//--- verilog/hsil_top.sv
`timescale 1ns/1ps
module hsil_top
	import hsil_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Receive data-link bit stream, clk_i domain
	input wire logic rx_bit_valid_i,
	input wire logic rx_bit_i,
	// Controller event pulses
	input wire logic fcs_err_i,
	input wire logic rx_start_i,
	input wire logic rx_end_i,
	input wire logic tx_start_i,
	input wire logic tx_end_i,
	input wire logic crc_bad_frame_i,
	input wire logic crc_good_frame_i,
	input wire logic msg_byte_i,
	input wire logic msg_done_i,
	// Interrupt request
	output logic irq_o
);
	import hsil_pkg::*;

	// ==================================================
	// Register state
	logic [2:0] link_en, next_link_en;
	logic [5:0] ss7_en, next_ss7_en;
	logic [5:0] ss7_stat, next_ss7_stat;
	logic [2:0] link_stat, next_link_stat;
	logic thresh_sel, next_thresh_sel;
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr, next_irq;

	// ==================================================
	// Detector state
	logic [7:0] shift, next_shift;
	logic [2:0] ones, next_ones;
	logic [6:0] crc_cnt, next_crc_cnt;
	logic [8:0] byte_cnt, next_byte_cnt;
	logic over_seen, next_over_seen;
	logic flag_hit, abort_hit, crc_hit, over_hit;

	function automatic logic sel_reg(input logic [7:0] a,
		input logic [7:0] b);
		sel_reg = (a == b);
	endfunction : sel_reg

	logic acc, wr, rd;
	assign acc = psel_i && penable_i && !pready_o;
	assign wr = acc && pwrite_i;
	assign rd = acc && !pwrite_i;

	// ==================================================
	// Stream detectors
	always_comb begin
		next_shift = shift;
		next_ones = ones;
		flag_hit = 1'b0;
		abort_hit = 1'b0;
		if (rx_bit_valid_i) begin
			next_shift = {rx_bit_i, shift[7:1]};
			flag_hit = (next_shift == FLAG_OCTET);
			if (rx_bit_i) begin
				// Saturate so a long run of ones reports once
				if (ones != 3'(ABORT_ONES)) begin
					next_ones = ones + 3'h1;
					abort_hit = (ones == 3'(ABORT_ONES - 1));
				end
			end else begin
				next_ones = 3'h0;
			end
		end
	end

	// Threshold counts consecutive corrupted frames; a good one restarts
	always_comb begin
		logic [6:0] lim;
		lim = thresh_sel ? CRC_THRESH_HIGH : CRC_THRESH_LOW;
		next_crc_cnt = crc_cnt;
		crc_hit = 1'b0;
		if (crc_good_frame_i) begin
			next_crc_cnt = 7'h00;
		end else if (crc_bad_frame_i && crc_cnt != lim) begin
			next_crc_cnt = crc_cnt + 7'h01;
			crc_hit = (crc_cnt + 7'h01 == lim);
		end
		next_byte_cnt = byte_cnt;
		next_over_seen = over_seen;
		over_hit = 1'b0;
		if (msg_done_i) begin
			next_byte_cnt = 9'h000;
			next_over_seen = 1'b0;
		end else if (msg_byte_i) begin
			if (byte_cnt != 9'h1ff) begin
				next_byte_cnt = byte_cnt + 9'h001;
			end
			// One report per message, on byte 277
			if (byte_cnt == MAX_MSG_BYTES && !over_seen) begin
				over_hit = 1'b1;
				next_over_seen = 1'b1;
			end
		end
	end

	// ==================================================
	// Registers and bus
	always_comb begin
		logic [5:0] ss7_set;
		logic [2:0] link_set;
		ss7_set = '0;
		ss7_set[TX_START_BIT] = tx_start_i;
		ss7_set[TX_END_BIT] = tx_end_i;
		ss7_set[RX_START_BIT] = rx_start_i;
		ss7_set[RX_END_BIT] = rx_end_i;
		ss7_set[CRC_FAIL_BIT] = crc_hit;
		ss7_set[OVERSIZE_BIT] = over_hit;
		link_set = '0;
		link_set[FCS_BIT] = fcs_err_i;
		link_set[ABORT_BIT] = abort_hit;
		link_set[IDLE_BIT] = flag_hit;
		next_link_en = link_en;
		next_ss7_en = ss7_en;
		next_thresh_sel = thresh_sel;
		next_ss7_stat = ss7_stat;
		next_link_stat = link_stat;
		next_prdata = prdata_o;
		next_pready = acc;
		next_pslverr = 1'b0;
		if (wr) begin
			if (sel_reg(paddr_i, LINK_IRQ_ENABLE_TWO_ADDR)) begin
				next_link_en = pwdata_i[2:0];
			end else if (sel_reg(paddr_i, SS7_EVENT_ENABLE_ADDR)) begin
				next_ss7_en = pwdata_i[5:0];
			end else if (sel_reg(paddr_i, CRC_CTRL_ADDR)) begin
				next_thresh_sel = pwdata_i[THRESH_SEL_BIT];
			end else if (!sel_reg(paddr_i, SS7_EVENT_STATUS_ADDR) &&
				!sel_reg(paddr_i, LINK_STATUS_ADDR)) begin
				next_pslverr = 1'b1;
			end
		end
		if (rd) begin
			next_prdata = 32'h0000_0000;
			if (sel_reg(paddr_i, LINK_IRQ_ENABLE_TWO_ADDR)) begin
				next_prdata[2:0] = link_en;
			end else if (sel_reg(paddr_i, SS7_EVENT_ENABLE_ADDR)) begin
				next_prdata[5:0] = ss7_en;
			end else if (sel_reg(paddr_i, CRC_CTRL_ADDR)) begin
				next_prdata[THRESH_SEL_BIT] = thresh_sel;
			end else if (sel_reg(paddr_i, SS7_EVENT_STATUS_ADDR)) begin
				next_prdata[5:0] = ss7_stat;
				next_ss7_stat = 6'h00;
			end else if (sel_reg(paddr_i, LINK_STATUS_ADDR)) begin
				next_prdata[2:0] = link_stat;
				next_link_stat = 3'h0;
			end else begin
				next_pslverr = 1'b1;
			end
		end
		// A new event in the read cycle survives the clear
		next_ss7_stat = next_ss7_stat | ss7_set;
		next_link_stat = next_link_stat | link_set;
		next_irq = |(next_ss7_stat & next_ss7_en) |
			|(next_link_stat & next_link_en);
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			link_en <= LINK_EN_RESET;
			ss7_en <= SS7_EN_RESET;
			ss7_stat <= SS7_STAT_RESET;
			link_stat <= LINK_STAT_RESET;
			thresh_sel <= 1'b0;
			prdata_o <= 32'h0000_0000;
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			irq_o <= 1'b0;
			shift <= 8'h00;
			ones <= 3'h0;
			crc_cnt <= 7'h00;
			byte_cnt <= 9'h000;
			over_seen <= 1'b0;
		end else begin
			link_en <= next_link_en;
			ss7_en <= next_ss7_en;
			ss7_stat <= next_ss7_stat;
			link_stat <= next_link_stat;
			thresh_sel <= next_thresh_sel;
			prdata_o <= next_prdata;
			pready_o <= next_pready;
			pslverr_o <= next_pslverr;
			irq_o <= next_irq;
			shift <= next_shift;
			ones <= next_ones;
			crc_cnt <= next_crc_cnt;
			byte_cnt <= next_byte_cnt;
			over_seen <= next_over_seen;
		end
	end
endmodule : hsil_top

//--- test/hsil_checker.sv
`timescale 1ns/1ps
// ==========
// Port checks
module hsil_checker (
	input wire logic clk_i, rst_n_i, psel_i, penable_i, pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i, prdata_o,
	input wire logic pready_o, pslverr_o, rx_bit_valid_i, rx_bit_i,
	input wire logic fcs_err_i, rx_start_i, rx_end_i, tx_start_i,
	input wire logic tx_end_i, crc_bad_frame_i, crc_good_frame_i,
	input wire logic msg_byte_i, msg_done_i, irq_o
);
	logic ev;
	logic mapped;
	assign ev = fcs_err_i | rx_start_i | rx_end_i | tx_start_i | tx_end_i
		| crc_bad_frame_i | rx_bit_valid_i | msg_byte_i;
	assign mapped = paddr_i inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	ready_wait_a: assert property (psel_i && penable_i && !pready_o
		|=> pready_o) else $error("ready late");
	ready_pulse_a: assert property (pready_o |=> !pready_o)
		else $error("ready too long");
	ready_cause_a: assert property (pready_o |-> $past(psel_i && penable_i))
		else $error("ready without access");
	err_map_a: assert property (pslverr_o |-> pready_o && !mapped)
		else $error("error on mapped address");
	map_ok_a: assert property (pready_o && !mapped |-> pslverr_o)
		else $error("no error on unmapped address");
	rdata_hold_a: assert property (!$stable(prdata_o)
		|-> $past(psel_i && !pwrite_i)) else $error("read data moved");
	irq_rise_a: assert property ($rose(irq_o)
		|-> $past(ev) || pready_o) else $error("irq no cause");
	irq_fall_a: assert property ($fell(irq_o) |-> pready_o)
		else $error("irq fell without access");
endmodule : hsil_checker
bind hsil_top hsil_checker hsil_checker_i (.*);

//--- test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import hsil_pkg::*;
	logic clk_i = 0, rst_n_i = 0, psel = 0, pen = 0, pwr = 0;
	logic [7:0] pa = 0;
	logic [31:0] pwd = 0, prd, rd;
	logic prdy, perr, rbv = 0, rb = 0, irq, er;
	logic [8:0] ev = 0;
	int n_errors = 0, num_checks = 0, cyc = 0;
	hsil_top hsil_top_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel),
		.penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd),
		.prdata_o(prd), .pready_o(prdy), .pslverr_o(perr),
		.rx_bit_valid_i(rbv), .rx_bit_i(rb), .fcs_err_i(ev[0]),
		.rx_start_i(ev[1]), .rx_end_i(ev[2]), .tx_start_i(ev[3]),
		.tx_end_i(ev[4]), .crc_bad_frame_i(ev[5]), .crc_good_frame_i(ev[6]),
		.msg_byte_i(ev[7]), .msg_done_i(ev[8]), .irq_o(irq));
	initial forever #20 clk_i = ~clk_i;
	// ==========
	// Tasks
	task automatic final_report();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : final_report
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			final_report();
		end
	end
	task automatic chk(input logic [31:0] s, e);
		num_checks++;
		if (s !== e) begin
			n_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, logic [31:0] d);
		@(posedge clk_i);
		psel <= 1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk_i);
		pen <= 1;
		// Look at the answer away from the edge that launches it
		do @(negedge clk_i); while (prdy !== 1'b1);
		rd = prd;
		er = perr;
		@(posedge clk_i);
		psel <= 0;
		pen <= 0;
	endtask : apb
	task automatic rdx(input logic [7:0] a, input logic [31:0] e);
		apb(0, a, 0);
		chk(rd, e);
	endtask : rdx
	// Consecutive pulses model back-to-back frames or bytes
	task automatic pulse(input int b, input int n);
		repeat (n) begin
			@(posedge clk_i);
			ev <= 9'h1 << b;
		end
		@(posedge clk_i);
		ev <= 0;
		repeat (2) @(posedge clk_i);
	endtask : pulse
	task automatic bits(input logic [7:0] v, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_i);
			rbv <= 1;
			rb <= v[i];
		end
		@(posedge clk_i);
		rbv <= 0;
		rb <= ~rb;
		repeat (2) @(posedge clk_i);
	endtask : bits
	initial begin
		logic [31:0] r;
		int evx[4] = '{3, 1, 4, 2};
		r = $urandom(2);
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1;
		rdx(LINK_IRQ_ENABLE_TWO_ADDR, 0);
		rdx(SS7_EVENT_STATUS_ADDR, 0);
		rdx(SS7_EVENT_ENABLE_ADDR, 0);
		apb(0, 8'h14, 0);
		chk(er, 1);
		r = $urandom;
		apb(1, SS7_EVENT_ENABLE_ADDR, r);
		rdx(SS7_EVENT_ENABLE_ADDR, r & 32'h3f);
		$display("reset and enables done");
		for (int i = 0; i < 4; i++) begin
			apb(1, SS7_EVENT_ENABLE_ADDR, i[0] << (5 - i));
			pulse(evx[i], 1);
			chk(irq, i[0]);
			rdx(SS7_EVENT_STATUS_ADDR, 1 << (5 - i));
			rdx(SS7_EVENT_STATUS_ADDR, 0);
			chk(irq, 0);
		end
		$display("start and end events done");
		pulse(0, 1);
		chk(irq, 0);
		rdx(LINK_STATUS_ADDR, 32'h4);
		apb(1, LINK_IRQ_ENABLE_TWO_ADDR, 32'h4);
		pulse(0, 1);
		chk(irq, 1);
		rdx(LINK_STATUS_ADDR, 32'h4);
		apb(1, LINK_IRQ_ENABLE_TWO_ADDR, 32'h3);
		bits(FLAG_OCTET, 8);
		chk(irq, 1);
		rdx(LINK_STATUS_ADDR, 32'h1);
		bits(8'hff, 7);
		chk(irq, 1);
		rdx(LINK_STATUS_ADDR, 32'h2);
		$display("link events done");
		apb(1, SS7_EVENT_ENABLE_ADDR, 32'h2);
		pulse(5, 31);
		rdx(SS7_EVENT_STATUS_ADDR, 0);
		pulse(5, 1);
		chk(irq, 1);
		rdx(SS7_EVENT_STATUS_ADDR, 32'h2);
		apb(1, CRC_CTRL_ADDR, 1);
		pulse(6, 1);
		pulse(5, 63);
		rdx(SS7_EVENT_STATUS_ADDR, 0);
		pulse(5, 1);
		rdx(SS7_EVENT_STATUS_ADDR, 32'h2);
		$display("crc threshold done");
		apb(1, SS7_EVENT_ENABLE_ADDR, 0);
		pulse(7, 276);
		rdx(SS7_EVENT_STATUS_ADDR, 0);
		pulse(7, 1);
		chk(irq, 0);
		rdx(SS7_EVENT_STATUS_ADDR, 32'h1);
		pulse(8, 1);
		apb(1, SS7_EVENT_ENABLE_ADDR, 32'h1);
		pulse(7, 277);
		chk(irq, 1);
		rdx(SS7_EVENT_STATUS_ADDR, 32'h1);
		pulse(8, 1);
		$display("oversize done");
		final_report();
	end
endmodule : tb_top
